// ==== inc/dma_pkg.sv ====
package dma_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int          NUM_CH = 3;
  localparam logic [11:0] SRC_OFS  [NUM_CH] = '{12'h100, 12'h140, 12'h160};
  localparam logic [11:0] DST_OFS  [NUM_CH] = '{12'h104, 12'h144, 12'h164};
  localparam logic [11:0] CTRL_OFS [NUM_CH] = '{12'h108, 12'h148, 12'h168};
  localparam logic [11:0] CNT_OFS  [NUM_CH] = '{12'h10c, 12'h14c, 12'h16c};
  localparam logic [11:0] STAT_OFS [NUM_CH] = '{12'h110, 12'h150, 12'h170};
  localparam logic [11:0] PARK_OFS = 12'h00c;
  localparam logic [11:0] ISR_OFS  = 12'h010;
  localparam logic [11:0] IMR_OFS  = 12'h014;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int          INT_BIT       = 31;
  localparam int          EXTERNAL_REQUEST_ENABLE_BIT      = 30;
  localparam int          CS_BIT        = 29;
  localparam int          AA_BIT        = 28;
  localparam int          SOURCE_INCREMENT_ENABLE_BIT      = 22;
  localparam int          SOURCE_SIZE_FIELD_LSB     = 20;
  localparam int          DEST_INCREMENT_ENABLE_BIT      = 19;
  localparam int          DEST_SIZE_FIELD_LSB     = 17;
  localparam int          START_BIT     = 16;
  localparam int          EXT_OPT_BIT   = 15;
  localparam int          PARK_WIDE_BIT = 24;
  localparam int          STAT_DONE_BIT = 0;
  localparam int          STAT_CE_BIT   = 1;
  localparam int          STAT_BSY_BIT  = 2;
  localparam int          NARROW_LSB    = 16;
  localparam logic [31:0] CTRL_WMASK    = 32'hfe7e_0000;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
  localparam logic [23:0] CNT_RST       = 24'h00_0000;
  localparam logic [5:0]  IRQ_RST       = 6'h00;

  // Access size encoding of the size fields
  typedef enum logic [1:0] {
    SZ_LONG = 2'h0,
    SZ_BYTE = 2'h1,
    SZ_WORD = 2'h2,
    SZ_LINE = 2'h3
  } size_type;

  // Bytes moved by one access of a given size
  function automatic logic [23:0] size_bytes(input size_type s);
    case (s)
      SZ_BYTE: size_bytes = 24'h00_0001;
      SZ_WORD: size_bytes = 24'h00_0002;
      SZ_LINE: size_bytes = 24'h00_0010;
      default: size_bytes = 24'h00_0004;
    endcase
  endfunction

  // Ordering of sizes, byte smallest
  function automatic logic [1:0] size_rank(input size_type s);
    case (s)
      SZ_BYTE: size_rank = 2'h0;
      SZ_WORD: size_rank = 2'h1;
      SZ_LINE: size_rank = 2'h3;
      default: size_rank = 2'h2;
    endcase
  endfunction

endpackage

// ==== inc/dma_ch_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Link between the register core and one channel sequencer
interface dma_ch_if;
  import dma_pkg::*;
  logic [31:0] ctrl;
  logic        wide;
  logic        start;
  logic        ext_req;
  logic        wr_src;
  logic        wr_dst;
  logic        wr_cnt;
  logic        clr_stat;
  logic [31:0] wdata;
  logic [31:0] src;
  logic [31:0] dst;
  logic [23:0] cnt;
  logic        done;
  logic        cfg_err;
  logic        busy;
  logic        done_evt;
  logic        err_evt;
  logic        bus_req;
  logic        bus_write;
  logic [31:0] bus_addr;
  size_type    bus_size;
  logic        ack;
  modport chan (input ctrl, wide, start, ext_req, wr_src, wr_dst, wr_cnt,
                clr_stat, wdata, ack,
                output src, dst, cnt, done, cfg_err, busy, done_evt,
                err_evt, bus_req, bus_write, bus_addr, bus_size);
  modport core (output ctrl, wide, start, ext_req, wr_src, wr_dst, wr_cnt,
                clr_stat, wdata, ack,
                input src, dst, cnt, done, cfg_err, busy, done_evt,
                err_evt, bus_req, bus_write, bus_addr, bus_size);
endinterface
`default_nettype wire

// ==== design/dma_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_channel
  import dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dma_ch_if.chan   ch
);

  // ************************************************************
  // Decode of the control word
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} state_type;

  state_type   st_ff;
  state_type   nxt_st;
  logic [31:0] src_ff;
  logic [31:0] dst_ff;
  logic [23:0] cnt_ff;
  logic        done_ff;
  logic        ce_ff;
  size_type    s_size;
  size_type    d_size;
  logic        req;
  logic        misalign;
  logic        src_align;
  logic        src_step;
  logic        dst_step;
  logic [23:0] cnt_next;
  logic        rd_ack;
  logic        wr_ack;
  logic        go;
  logic        set_done;
  logic        set_ce;
  logic [23:0] cnt_load;

  assign s_size    = size_type'(ch.ctrl[SOURCE_SIZE_FIELD_LSB +: 2]);
  assign d_size    = size_type'(ch.ctrl[DEST_SIZE_FIELD_LSB +: 2]);
  // Start bit always requests, pin only when enabled
  assign req       = ch.start | (ch.ext_req & ch.ctrl[EXTERNAL_REQUEST_ENABLE_BIT]);
  // Count must be a whole number of write accesses
  assign misalign  = |(cnt_ff & (size_bytes(d_size) - 24'h00_0001));
  // Source side wins when it is not the narrower one
  assign src_align = ch.ctrl[AA_BIT] & (size_rank(s_size) >= size_rank(d_size));
  assign src_step  = ch.ctrl[SOURCE_INCREMENT_ENABLE_BIT] | src_align;
  assign dst_step  = ch.ctrl[DEST_INCREMENT_ENABLE_BIT] | (ch.ctrl[AA_BIT] & ~src_align);
  assign cnt_next  = cnt_ff - size_bytes(d_size);
  assign rd_ack    = (st_ff == ST_READ) & ch.ack;
  assign wr_ack    = (st_ff == ST_WRITE) & ch.ack;
  assign go        = (st_ff == ST_IDLE) & req & ~misalign & (cnt_ff != CNT_RST);
  assign set_ce    = (st_ff == ST_IDLE) & req & misalign;
  assign set_done  = (wr_ack & (cnt_next == CNT_RST))
                   | ((st_ff == ST_IDLE) & req & (cnt_ff == CNT_RST));
  // Narrow mode takes the upper half-word of the written data
  assign cnt_load  = ch.wide ? ch.wdata[23:0]
                             : {8'h00, ch.wdata[31:NARROW_LSB]};

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Continuous mode loops read/write pairs, cycle steal stops after one
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:  if (go) nxt_st = ST_READ;
      ST_READ:  if (rd_ack) nxt_st = ST_WRITE;
      ST_WRITE: begin
        if (wr_ack) begin
          if (cnt_next == CNT_RST || ch.ctrl[CS_BIT]) nxt_st = ST_IDLE;
          else nxt_st = ST_READ;
        end
      end
      default:  nxt_st = ST_IDLE;
    endcase
  end

  // Addresses and count; software writes lose to nothing while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff  <= ST_IDLE;
      src_ff <= ADDR_RST;
      dst_ff <= ADDR_RST;
      cnt_ff <= CNT_RST;
    end else begin
      st_ff <= nxt_st;
      if (ch.wr_src) src_ff <= ch.wdata;
      else if (rd_ack && src_step) src_ff <= src_ff + {8'h00, size_bytes(s_size)};
      if (ch.wr_dst) dst_ff <= ch.wdata;
      else if (wr_ack && dst_step) dst_ff <= dst_ff + {8'h00, size_bytes(d_size)};
      if (ch.wr_cnt) cnt_ff <= cnt_load;
      else if (wr_ack) cnt_ff <= cnt_next;
    end
  end

  // Status flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      ce_ff   <= 1'b0;
    end else begin
      done_ff <= set_done | (done_ff & ~ch.clr_stat);
      ce_ff   <= set_ce | (ce_ff & ~ch.clr_stat);
    end
  end

  assign ch.src       = src_ff;
  assign ch.dst       = dst_ff;
  assign ch.cnt       = cnt_ff;
  assign ch.done      = done_ff;
  assign ch.cfg_err   = ce_ff;
  assign ch.busy      = (st_ff != ST_IDLE);
  assign ch.done_evt  = set_done;
  assign ch.err_evt   = set_ce;
  assign ch.bus_req   = (st_ff != ST_IDLE);
  assign ch.bus_write = (st_ff == ST_WRITE);
  assign ch.bus_addr  = (st_ff == ST_WRITE) ? dst_ff : src_ff;
  assign ch.bus_size  = (st_ff == ST_WRITE) ? d_size : s_size;

endmodule
`default_nettype wire

// ==== design/dma_channel_count_and_control.sv ====
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_count_and_control
  import dma_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [2:0]  EXT_REQ_N,
  output logic             BUS_REQ,
  output logic             BUS_WRITE,
  output logic      [31:0] BUS_ADDR,
  output logic      [1:0]  BUS_SIZE,
  output logic      [31:0] BUS_WDATA,
  input  wire logic [31:0] BUS_RDATA,
  input  wire logic        BUS_ACK,
  output logic             IRQ
);

  // ************************************************************
  // Declarations
  // ************************************************************
  dma_ch_if chif [NUM_CH] ();

  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        wide_ff;
  logic [5:0]  isr_ff;
  logic [5:0]  imr_ff;
  logic [5:0]  nxt_isr;
  logic        irq_ff;
  logic [31:0] ctrl_ff   [NUM_CH];
  logic [NUM_CH-1:0] start_ff;
  logic [NUM_CH-1:0] sync1_ff;
  logic [NUM_CH-1:0] sync2_ff;
  logic [NUM_CH-1:0] sync3_ff;
  logic [NUM_CH-1:0] ext_lvl_ff;
  logic [NUM_CH-1:0] ext_pulse_ff;
  logic        bus_req_ff;
  logic        bus_write_ff;
  logic [31:0] bus_addr_ff;
  logic [1:0]  bus_size_ff;
  logic [31:0] data_ff;
  logic [1:0]  owner_ff;
  logic        lock_ff;

  logic        setup;
  logic        access_done;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] ctrl_mask;
  logic        hit_park;
  logic        hit_isr;
  logic        hit_imr;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [31:0] ch_rd   [NUM_CH];
  logic [NUM_CH-1:0] ch_hit;
  logic [NUM_CH-1:0] ch_req;
  logic [NUM_CH-1:0] done_set;
  logic [NUM_CH-1:0] err_set;
  logic [31:0] ch_addr [NUM_CH];
  logic [1:0]  ch_size [NUM_CH];
  logic [NUM_CH-1:0] ch_wr;
  logic [1:0]  pick;
  logic        pick_ok;

  // ************************************************************
  // APB slave decode
  // ************************************************************
  // One wait-free access phase: ready rises in the first access cycle
  assign setup       = PSEL & ~PENABLE;
  assign access_done = PSEL & PENABLE & pready_ff;
  assign wr_en       = access_done & PWRITE;
  assign rd_en       = access_done & ~PWRITE;
  assign hit_park    = (PADDR == PARK_OFS);
  assign hit_isr     = (PADDR == ISR_OFS);
  assign hit_imr     = (PADDR == IMR_OFS);
  // Bit 15 only exists with the wide count layout
  assign ctrl_mask   = wide_ff ? (CTRL_WMASK | (32'h1 << EXT_OPT_BIT))
                               : CTRL_WMASK;

  // ************************************************************
  // Per-channel glue
  // ************************************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
    logic hit_src;
    logic hit_dst;
    logic hit_ctrl;
    logic hit_cnt;
    logic hit_stat;
    logic [31:0] cnt_rd;

    assign hit_src  = (PADDR == SRC_OFS[g]);
    assign hit_dst  = (PADDR == DST_OFS[g]);
    assign hit_ctrl = (PADDR == CTRL_OFS[g]);
    assign hit_cnt  = (PADDR == CNT_OFS[g]);
    assign hit_stat = (PADDR == STAT_OFS[g]);
    // Count reads back in the layout chosen by the park register
    assign cnt_rd   = wide_ff ? {8'h00, chif[g].cnt}
                              : {chif[g].cnt[15:0], 16'h0000};

    assign ch_hit[g] = hit_src | hit_dst | hit_ctrl | hit_cnt | hit_stat;
    assign ch_rd[g]  = ({32{hit_src}}  & chif[g].src)
                     | ({32{hit_dst}}  & chif[g].dst)
                     | ({32{hit_ctrl}} & ctrl_ff[g] & ctrl_mask)
                     | ({32{hit_cnt}}  & cnt_rd)
                     | ({32{hit_stat}} & {29'h0, chif[g].busy,
                                          chif[g].cfg_err, chif[g].done});

    assign chif[g].ctrl     = ctrl_ff[g];
    assign chif[g].wide     = wide_ff;
    assign chif[g].start    = start_ff[g];
    assign chif[g].ext_req  = ext_pulse_ff[g];
    assign chif[g].wdata    = PWDATA;
    assign chif[g].wr_src   = wr_en & hit_src;
    assign chif[g].wr_dst   = wr_en & hit_dst;
    assign chif[g].wr_cnt   = wr_en & hit_cnt;
    assign chif[g].clr_stat = wr_en & hit_stat & PWDATA[STAT_DONE_BIT];
    assign chif[g].ack      = bus_req_ff & BUS_ACK & (owner_ff == 2'(g));

    assign ch_req[g]   = chif[g].bus_req;
    assign ch_wr[g]    = chif[g].bus_write;
    assign ch_addr[g]  = chif[g].bus_addr;
    assign ch_size[g]  = chif[g].bus_size;
    // Only channels with interrupts enabled report events
    assign done_set[g] = chif[g].done_evt & ctrl_ff[g][INT_BIT];
    assign err_set[g]  = chif[g].err_evt & ctrl_ff[g][INT_BIT];

    // Control word; start is self-clearing and delayed so that it
    // sees the sizes written together with it
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
        ctrl_ff[g]  <= CTRL_RST;
        start_ff[g] <= 1'b0;
      end else begin
        if (wr_en && hit_ctrl) ctrl_ff[g] <= PWDATA & ctrl_mask;
        start_ff[g] <= wr_en & hit_ctrl & PWDATA[START_BIT];
      end
    end

    // Pin synchroniser; the level changes once stages two and three agree
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
        sync1_ff[g]     <= 1'b0;
        sync2_ff[g]     <= 1'b0;
        sync3_ff[g]     <= 1'b0;
        ext_lvl_ff[g]   <= 1'b0;
        ext_pulse_ff[g] <= 1'b0;
      end else begin
        sync1_ff[g]     <= ~EXT_REQ_N[g];
        sync2_ff[g]     <= sync1_ff[g];
        sync3_ff[g]     <= sync2_ff[g];
        if (sync2_ff[g] == sync3_ff[g]) ext_lvl_ff[g] <= sync3_ff[g];
        // One request per assertion of the pin
        ext_pulse_ff[g] <= (sync2_ff[g] == sync3_ff[g]) & sync3_ff[g]
                         & ~ext_lvl_ff[g];
      end
    end

    dma_channel u_chan (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .ch    (chif[g])
    );
  end

  // ************************************************************
  // Read data selection
  // ************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_mux[PARK_WIDE_BIT] = hit_park & wide_ff;
    rd_mux[5:0] = ({6{hit_isr}} & isr_ff) | ({6{hit_imr}} & imr_ff);
    for (int i = 0; i < NUM_CH; i++) begin
      rd_mux = rd_mux | ch_rd[i];
    end
  end

  assign rd_hit = hit_park | hit_isr | hit_imr | (|ch_hit);

  // Ready, read data and error are all captured in the setup cycle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~rd_hit;
      if (setup && !PWRITE) prdata_ff <= rd_mux;
    end
  end

  // ************************************************************
  // Park register, interrupt status and mask
  // ************************************************************
  // A read clears the status, but an event in that cycle survives
  assign nxt_isr = (isr_ff & ~{6{rd_en & hit_isr}}) | {err_set, done_set};

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wide_ff <= 1'b0;
      imr_ff  <= IRQ_RST;
      isr_ff  <= IRQ_RST;
      irq_ff  <= 1'b0;
    end else begin
      if (wr_en && hit_park) wide_ff <= PWDATA[PARK_WIDE_BIT];
      if (wr_en && hit_imr) imr_ff <= PWDATA[5:0];
      isr_ff <= nxt_isr;
      irq_ff <= |(nxt_isr & imr_ff);
    end
  end

  // ************************************************************
  // Bus arbitration and transfer issue
  // ************************************************************
  // Lowest channel first; a started read/write pair keeps the bus so
  // the held data cannot be overwritten by another channel
  always_comb begin
    pick    = owner_ff;
    pick_ok = lock_ff & ch_req[owner_ff];
    if (!lock_ff) begin
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (ch_req[i]) begin
          pick    = 2'(i);
          pick_ok = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_req_ff   <= 1'b0;
      bus_write_ff <= 1'b0;
      bus_addr_ff  <= ADDR_RST;
      bus_size_ff  <= 2'h0;
      data_ff      <= 32'h0000_0000;
      owner_ff     <= 2'h0;
      lock_ff      <= 1'b0;
    end else if (bus_req_ff) begin
      if (BUS_ACK) begin
        bus_req_ff <= 1'b0;
        lock_ff    <= ~bus_write_ff;
        if (!bus_write_ff) data_ff <= BUS_RDATA;
      end
    end else if (pick_ok) begin
      bus_req_ff   <= 1'b1;
      owner_ff     <= pick;
      bus_write_ff <= ch_wr[pick];
      bus_addr_ff  <= ch_addr[pick];
      bus_size_ff  <= ch_size[pick];
    end
  end

  assign PRDATA    = prdata_ff;
  assign PREADY    = pready_ff;
  assign PSLVERR   = pslverr_ff;
  assign BUS_REQ   = bus_req_ff;
  assign BUS_WRITE = bus_write_ff;
  assign BUS_ADDR  = bus_addr_ff;
  assign BUS_SIZE  = bus_size_ff;
  assign BUS_WDATA = data_ff;
  assign IRQ       = irq_ff;

endmodule
`default_nettype wire

// ==== bench/dma_far_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side memory slave: acks each address phase, promptly or after a random stall
module dma_far_bus_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        write,
  input  wire logic [31:0] addr,
  input  wire logic        slow,
  output logic             ack,
  output logic      [31:0] rdata
);
  int dly;
  int seed;
  // Data is only valid with ack; otherwise it toggles so stale values never pass
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack   <= 1'b0;
      rdata <= 32'h5a5a_5a5a;
      dly   <= 0;
      seed  = 29;
    end else begin
      rdata <= ~rdata;
      ack   <= 1'b0;
      if (req && !ack && dly != 0) begin
        dly <= dly - 1;
      end else if (req && !ack) begin
        ack <= 1'b1;
        dly <= slow ? ($random(seed) & 3) : 0;
        if (!write) begin
          rdata <= addr ^ 32'hc3a5_96f0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/dma_channel_count_and_control_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_channel_count_and_control_asserts
  import dma_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [2:0]  EXT_REQ_N,
  input wire logic        BUS_REQ,
  input wire logic        BUS_WRITE,
  input wire logic [31:0] BUS_ADDR,
  input wire logic [1:0]  BUS_SIZE,
  input wire logic [31:0] BUS_WDATA,
  input wire logic [31:0] BUS_RDATA,
  input wire logic        BUS_ACK,
  input wire logic        IRQ
);
  logic [31:0] rd_ff;
  logic        wr_ff;
  // Remember the read half of each pair so the write can be tied to it
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ff <= 32'h0000_0000;
      wr_ff <= 1'b1;
    end else if (BUS_REQ && BUS_ACK) begin
      rd_ff <= BUS_WRITE ? rd_ff : BUS_RDATA;
      wr_ff <= BUS_WRITE;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  bus_hold_a: assert property (BUS_REQ && !BUS_ACK |=> BUS_REQ && $stable(BUS_ADDR)
    && $stable(BUS_WRITE) && $stable(BUS_SIZE)) else $error("bus request moved before ack");
  ack_drop_a: assert property (BUS_REQ && BUS_ACK |=> !BUS_REQ)
    else $error("bus request held after ack");
  req_gap_a: assert property ($fell(BUS_REQ) && !BUS_WRITE |=> BUS_REQ && BUS_WRITE)
    else $error("write did not follow its read");
  pair_order_a: assert property ($rose(BUS_REQ) |-> BUS_WRITE != wr_ff)
    else $error("read and write not alternating");
  wdata_pair_a: assert property (BUS_REQ && BUS_WRITE |-> BUS_WDATA == rd_ff)
    else $error("write data differs from read data");
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  slverr_with_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  reset_quiet_a: assert property ($rose(RST_N) |-> !BUS_REQ && !IRQ)
    else $error("outputs active after reset");
  cover property (BUS_REQ && BUS_ACK && BUS_WRITE);
  cover property (PSLVERR);
  cover property ($rose(IRQ));
endmodule
bind dma_channel_count_and_control dma_channel_count_and_control_asserts
  u_dma_channel_count_and_control_asserts (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_REQ_N(EXT_REQ_N),
  .BUS_REQ(BUS_REQ), .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR), .BUS_SIZE(BUS_SIZE),
  .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .BUS_ACK(BUS_ACK), .IRQ(IRQ));
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dma_pkg::*;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, slow;
  logic        bus_req, bus_write, bus_ack, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, bus_addr, bus_wdata, bus_rdata;
  logic [1:0]  bus_size;
  logic [2:0]  ext_req_n;
  logic [4:0]  sz_bytes [4] = '{5'h04, 5'h01, 5'h02, 5'h10};
  int          n_mismatch, samples_checked, seed, n_wr, exp_src, step, cnt, sz;
  int          exp_dst, dstep;
  logic [31:0] exp_wd;
  dma_channel_count_and_control u_dma_channel_count_and_control (.SYS_CLK(sys_clk),
    .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_REQ_N(ext_req_n), .BUS_REQ(bus_req), .BUS_WRITE(bus_write), .BUS_ADDR(bus_addr),
    .BUS_SIZE(bus_size), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata), .BUS_ACK(bus_ack),
    .IRQ(irq));
  dma_far_bus_model u_dma_far_bus_model (.clk(sys_clk), .rst_n(rst_n), .req(bus_req),
    .write(bus_write), .addr(bus_addr), .slow(slow), .ack(bus_ack), .rdata(bus_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ************************************************************
  // Checking and bus tasks
  // ************************************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Ready and read data are taken at the rising edge that completes the access
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task wait_done(input int c);
    repeat (200) begin
      apb(1'b0, STAT_OFS[c], 32'h0);
      if (rd[1:0] != 2'h0) break;
    end
  endtask
  task pend(input int n);
    repeat (100) @(posedge sys_clk) if (n_wr == n) break;
    repeat (30) @(posedge sys_clk);
  endtask
  // Reference model: write acks counted, source address walked by access size
  always @(posedge sys_clk) if (bus_req && bus_ack) begin
    chk("size", bus_size, sz);
    if (bus_write) begin
      n_wr++;
      chk("wdata", bus_wdata, exp_wd);
      chk("dst addr", bus_addr, exp_dst);
      exp_dst += dstep;
    end else begin
      chk("src addr", bus_addr, exp_src);
      exp_wd = exp_src ^ 32'hc3a5_96f0;
      exp_src += step;
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish;
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow, rst_n, err} = '0;
    {ext_req_n, seed, n_wr, exp_src, step, sz, n_mismatch, samples_checked} = {3'h7, 32'd29, 192'h0};
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, CNT_OFS[0], 32'h0);
    chk("count reset", rd, 32'h0);
    apb(1'b1, 12'hff0, 32'h1);
    chk("unmapped", err, 1'b1);
    apb(1'b1, IMR_OFS, 32'h3f);
    // Continuous blocks for each size, narrow then wide count layout
    for (int w = 0; w < 2; w++) for (int s = 0; s < 4; s++) begin
      sz = s;
      step = sz_bytes[s];
      cnt = step * (($random(seed) & 3) + 1);
      slow <= s[0];
      apb(1'b1, PARK_OFS, w << PARK_WIDE_BIT);
      apb(1'b1, CTRL_OFS[1], 32'h8000);
      apb(1'b0, CTRL_OFS[1], 32'h0);
      chk("opt bit", rd[15], w);
      exp_src = {$random(seed)} & 32'h0000_fff0;
      apb(1'b1, SRC_OFS[0], exp_src);
      apb(1'b1, DST_OFS[0], 32'h0000_8000);
      {exp_dst, dstep} = {32'h0000_8000, step};
      apb(1'b1, CNT_OFS[0], w ? cnt : cnt << 16);
      apb(1'b0, CNT_OFS[0], 32'h0);
      chk("count layout", rd, w ? cnt : cnt << 16);
      n_wr = 0;
      apb(1'b1, CTRL_OFS[0], (1 << INT_BIT) | (1 << AA_BIT) | (s << SOURCE_SIZE_FIELD_LSB)
          | (1 << DEST_INCREMENT_ENABLE_BIT) | (s << DEST_SIZE_FIELD_LSB) | (1 << START_BIT));
      wait_done(0);
      chk("done", rd[1:0], 2'h1);
      chk("writes", n_wr, cnt / step);
      apb(1'b0, CNT_OFS[0], 32'h0);
      chk("count end", rd, 32'h0);
      chk("irq on", irq, 1'b1);
      apb(1'b0, ISR_OFS, 32'h0);
      chk("isr", rd[5:0], 6'h01);
      // The interrupt drops at the edge that completes the clearing read
      @(negedge sys_clk);
      chk("irq off", irq, 1'b0);
      apb(1'b1, STAT_OFS[0], 32'h1);
    end
    // Word count that is not even: config error, nothing moves
    {sz, step, n_wr} = {32'h2, 32'h2, 32'h0};
    apb(1'b1, CNT_OFS[2], 32'h3);
    apb(1'b1, CTRL_OFS[2], (1 << INT_BIT) | (2 << DEST_SIZE_FIELD_LSB) | (1 << START_BIT));
    wait_done(2);
    chk("cfg err", rd[1:0], 2'h2);
    apb(1'b0, ISR_OFS, 32'h0);
    chk("isr err", rd[5:0], 6'h20);
    chk("no move", n_wr, 0);
    // Cycle steal: one pair per start, then per pin request when enabled
    {sz, step, n_wr} = {32'h0, 32'h4, 32'h0};
    exp_src = 32'h0000_0200;
    {exp_dst, dstep} = 64'h0;
    apb(1'b1, SRC_OFS[1], exp_src);
    apb(1'b1, CNT_OFS[1], 32'h8);
    apb(1'b1, CTRL_OFS[1], (1 << CS_BIT) | (1 << SOURCE_INCREMENT_ENABLE_BIT) | (1 << START_BIT));
    pend(1);
    chk("steal one", n_wr, 1);
    apb(1'b0, CNT_OFS[1], 32'h0);
    chk("steal count", rd, 32'h4);
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, CTRL_OFS[1], (e << EXTERNAL_REQUEST_ENABLE_BIT) | (1 << CS_BIT) | (1 << SOURCE_INCREMENT_ENABLE_BIT));
      ext_req_n <= 3'h5;
      repeat (10) @(posedge sys_clk);
      ext_req_n <= 3'h7;
      pend(1 + e);
      chk("pin request", n_wr, 1 + e);
    end
    apb(1'b0, STAT_OFS[1], 32'h0);
    chk("steal done", rd[1:0], 2'h1);
    chk("irq masked", irq, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
